//--- rtl/hotplug_mux_pkg.sv
package hotplug_mux_pkg;

  // ==========================================================
  // Pin and port geometry
  // ==========================================================
  localparam int unsigned NUM_GPIO = 19;
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned GROUP_A_WIDTH = 8;
  localparam int unsigned GROUP_B_WIDTH = 8;
  localparam int unsigned GROUP_C_WIDTH = 3;
  localparam int unsigned GROUP_B_FIRST = 8;
  localparam int unsigned GROUP_C_FIRST = 16;

  // First pin claimed by each downstream port's hot-plug strap
  localparam int unsigned PORT1_BASE_PIN = 0;
  localparam int unsigned PORT2_BASE_PIN = 4;
  localparam int unsigned PORT3_BASE_PIN = 8;

  // Position of each slot signal within a port's three pins
  localparam int unsigned ROLE_PRESENCE = 0;
  localparam int unsigned ROLE_POWER_ON = 1;
  localparam int unsigned ROLE_POWER_GOOD = 2;
  localparam int unsigned PINS_PER_PORT = 3;

  // ==========================================================
  // Register map (byte addresses on the APB)
  // ==========================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_GPIO_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_GPIO_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_GPIO_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_GPIO_DATA = 8'h0c;
  localparam logic [7:0] OFS_STRAP_STATUS = 8'h10;
  localparam logic [7:0] OFS_CLOCK_REQ = 8'h14;
  localparam logic [7:0] OFS_EEPROM_WIRE = 8'h18;

  // Field positions
  localparam int unsigned STAT_STRAP_LSB = 0;
  localparam int unsigned STAT_PRESENCE_LSB = 4;
  localparam int unsigned STAT_POWER_GOOD_LSB = 8;
  localparam int unsigned CLKREQ_SW_BIT = 0;
  localparam int unsigned CLKREQ_LINK_BIT = 1;
  localparam int unsigned EE_SCL_BIT = 0;
  localparam int unsigned EE_SDA_LOW_BIT = 1;
  localparam int unsigned EE_SDA_IN_BIT = 2;

  // Reset values
  localparam logic [7:0] RST_GPIO_CTRL_A = 8'h00;
  localparam logic [7:0] RST_GPIO_CTRL_B = 8'h00;
  localparam logic [2:0] RST_GPIO_CTRL_C = 3'h0;
  localparam logic [18:0] RST_GPIO_DATA = 19'h00000;
  localparam logic RST_CLKREQ_SW = 1'b0;
  localparam logic RST_EE_SCL = 1'b1;
  localparam logic RST_EE_SDA_LOW = 1'b0;

endpackage

//--- rtl/strap_sampler.sv
`timescale 1ns/1ps
`default_nettype none

// Catches one strap level on the first clock after reset is released
// and keeps it until the next reset.
module strap_sampler
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic strap_in,
  output logic strap_q
);

  typedef struct packed {
    logic armed;
    logic value;
  } sampler_state_t;

  sampler_state_t cur_q;
  sampler_state_t nxt_d;

  // ==========================================================
  // Capture at release, ignore later strap movement
  // ==========================================================
  always_comb
  begin
    nxt_d = cur_q;
    if (reset)
    begin
      nxt_d.armed = 1'b1;
      nxt_d.value = 1'b0;
    end
    else if (cur_q.armed)
    begin
      nxt_d.armed = 1'b0;
      nxt_d.value = strap_in;
    end
  end

  // Reset is synchronous, so the strap is never loaded under reset
  always_ff @(posedge mclk)
  begin
    cur_q <= nxt_d;
  end

  assign strap_q = cur_q.value;

endmodule

`default_nettype wire

//--- rtl/gpio_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

// One general-purpose pin: either the register-driven path or a
// hot-plug role chosen by the port's strap.
module gpio_pin_cell
(
  input wire logic hp_claim,
  input wire logic hp_drives,
  input wire logic hp_value,
  input wire logic gpio_dir_out,
  input wire logic gpio_value,
  input wire logic pin_in,
  output logic pin_out_d,
  output logic pin_oe_n_d,
  output logic gpio_read,
  output logic hp_read
);

  // ==========================================================
  // Function select
  // ==========================================================
  always_comb
  begin
    if (hp_claim)
    begin
      pin_out_d = hp_drives ? hp_value : 1'b0;
      pin_oe_n_d = ~hp_drives;
      gpio_read = 1'b0;
      hp_read = hp_drives ? 1'b0 : pin_in;
    end
    else
    begin
      pin_out_d = gpio_dir_out ? gpio_value : 1'b0;
      pin_oe_n_d = ~gpio_dir_out;
      gpio_read = pin_in;
      hp_read = 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- rtl/hotplug_strap_gpio_mux.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Port 1 strap high at release gives pins 0..2 to hot-plug.
// - Port 2 strap high at release gives pins 4..6 to hot-plug.
// - Port 3 strap high at release gives pins 8..10 to hot-plug.
// - Lowest pin presence, middle power-on, highest power-good.
// - Strap low at release leaves the pins as ordinary GPIO.
// - Pins 0..7 follow control register A unless claimed.
// - Pins 8..15 follow control register B unless claimed.
// - Pins 16..18 follow control register C; no hot-plug role.
// - Clock request goes low to ask upstream to restore clock.
// - Global reset returns everything, straps too, to initial state.
// - EEPROM clock is output only; data line is bidirectional.
// - Fundamental reset low holds reset; its rise samples straps.
module hotplug_strap_gpio_mux
#(
  parameter int unsigned NUM_GPIO = hotplug_mux_pkg::NUM_GPIO
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic fundamental_reset_n,
  input wire logic global_power_on_reset_n,
  input wire logic port1_hotplug_strap,
  input wire logic port2_hotplug_strap,
  input wire logic port3_hotplug_strap,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hotplug_mux_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_GPIO-1:0] gpio_in,
  output logic [NUM_GPIO-1:0] gpio_out,
  output logic [NUM_GPIO-1:0] gpio_oe_n,
  input wire logic [2:0] slot_power_on,
  output logic [2:0] slot_presence,
  output logic [2:0] slot_power_good,
  input wire logic link_clock_needed,
  output logic upstream_clock_request_n,
  output logic eeprom_scl,
  input wire logic eeprom_sda_in,
  output logic eeprom_sda_out,
  output logic eeprom_sda_oe_n
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [2:0] ctrl_c;
    logic [NUM_GPIO-1:0] gpio_data;
    logic clkreq_sw;
    logic ee_scl;
    logic ee_sda_low;
    logic bus_ready;
    logic bus_err;
    logic [31:0] bus_rdata;
    logic [NUM_GPIO-1:0] pin_out;
    logic [NUM_GPIO-1:0] pin_oe_n;
    logic [2:0] presence;
    logic [2:0] power_good;
    logic clkreq_n;
  } mux_state_t;

  mux_state_t cur_q;
  mux_state_t nxt_d;

  logic sys_reset;
  logic [2:0] strap_q;
  logic [2:0] strap_raw;
  logic [NUM_GPIO-1:0] dir_out;
  logic [NUM_GPIO-1:0] hp_claim;
  logic [NUM_GPIO-1:0] hp_drives;
  logic [NUM_GPIO-1:0] hp_value;
  logic [NUM_GPIO-1:0] pin_out_d;
  logic [NUM_GPIO-1:0] pin_oe_n_d;
  logic [NUM_GPIO-1:0] gpio_read;
  logic [NUM_GPIO-1:0] hp_read;
  logic [2:0] presence_d;
  logic [2:0] power_good_d;
  logic access;
  logic wr_done;

  // ==========================================================
  // Reset sources
  // ==========================================================
  // Any of the three sources puts the whole block in reset; the
  // first clock edge after the last one releases is the strap sample point.
  // combined reset
  assign sys_reset = reset | ~fundamental_reset_n | ~global_power_on_reset_n;

  // ==========================================================
  // Strap capture, one per downstream port
  // ==========================================================
  assign strap_raw = {port3_hotplug_strap, port2_hotplug_strap,
                      port1_hotplug_strap};

  genvar gp;
  generate
    for (gp = 0; gp < hotplug_mux_pkg::NUM_PORTS; gp++)
    begin : g_strap
      strap_sampler u_strap
      (
        .mclk(mclk),
        .reset(sys_reset),
        .strap_in(strap_raw[gp]),
        .strap_q(strap_q[gp])
      );
    end
  endgenerate

  // ==========================================================
  // Pin ownership
  // ==========================================================
  // Direction bits of the three control registers laid end to end.
  // group control
  assign dir_out = {cur_q.ctrl_c, cur_q.ctrl_b, cur_q.ctrl_a};

  // Which pins a captured strap claims, and which role each takes.
  // Only the power-on role is driven by the device; presence and
  // power-good are slot inputs.
  always_comb
  begin
    hp_claim = '0;
    hp_drives = '0;
    hp_value = '0;
    if (strap_q[0])
    begin
      hp_claim[hotplug_mux_pkg::PORT1_BASE_PIN +: 3] = 3'h7;
    end
    if (strap_q[1])
    begin
      hp_claim[hotplug_mux_pkg::PORT2_BASE_PIN +: 3] = 3'h7;
    end
    if (strap_q[2])
    begin
      hp_claim[hotplug_mux_pkg::PORT3_BASE_PIN +: 3] = 3'h7;
    end
    hp_drives[hotplug_mux_pkg::PORT1_BASE_PIN +
              hotplug_mux_pkg::ROLE_POWER_ON] = 1'b1;
    hp_drives[hotplug_mux_pkg::PORT2_BASE_PIN +
              hotplug_mux_pkg::ROLE_POWER_ON] = 1'b1;
    hp_drives[hotplug_mux_pkg::PORT3_BASE_PIN +
              hotplug_mux_pkg::ROLE_POWER_ON] = 1'b1;
    hp_value[hotplug_mux_pkg::PORT1_BASE_PIN +
             hotplug_mux_pkg::ROLE_POWER_ON] = slot_power_on[0];
    hp_value[hotplug_mux_pkg::PORT2_BASE_PIN +
             hotplug_mux_pkg::ROLE_POWER_ON] = slot_power_on[1];
    hp_value[hotplug_mux_pkg::PORT3_BASE_PIN +
             hotplug_mux_pkg::ROLE_POWER_ON] = slot_power_on[2];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPIO; gi++)
    begin : g_pin
      gpio_pin_cell u_cell
      (
        .hp_claim(hp_claim[gi]),
        .hp_drives(hp_drives[gi]),
        .hp_value(hp_value[gi]),
        .gpio_dir_out(dir_out[gi]),
        .gpio_value(cur_q.gpio_data[gi]),
        .pin_in(gpio_in[gi]),
        .pin_out_d(pin_out_d[gi]),
        .pin_oe_n_d(pin_oe_n_d[gi]),
        .gpio_read(gpio_read[gi]),
        .hp_read(hp_read[gi])
      );
    end
  endgenerate

  // Slot inputs gathered per port; zero when the port is not strapped
  // presence and power-good
  assign presence_d = {
    hp_read[hotplug_mux_pkg::PORT3_BASE_PIN + hotplug_mux_pkg::ROLE_PRESENCE],
    hp_read[hotplug_mux_pkg::PORT2_BASE_PIN + hotplug_mux_pkg::ROLE_PRESENCE],
    hp_read[hotplug_mux_pkg::PORT1_BASE_PIN + hotplug_mux_pkg::ROLE_PRESENCE]
  };
  assign power_good_d = {
    hp_read[hotplug_mux_pkg::PORT3_BASE_PIN +
            hotplug_mux_pkg::ROLE_POWER_GOOD],
    hp_read[hotplug_mux_pkg::PORT2_BASE_PIN +
            hotplug_mux_pkg::ROLE_POWER_GOOD],
    hp_read[hotplug_mux_pkg::PORT1_BASE_PIN +
            hotplug_mux_pkg::ROLE_POWER_GOOD]
  };

  // ==========================================================
  // APB handshake
  // ==========================================================
  // One wait state: the first access cycle computes the answer, the
  // next edge sees pready high and commits the write. Registered
  // outputs cost a cycle but keep every bus output off a gate path.
  assign access = psel & penable & ~cur_q.bus_ready;
  assign wr_done = psel & penable & cur_q.bus_ready & pwrite;

  // Byte-lane merge of a write into a register value
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] lanes
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (lanes[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Read mux and decode error
  function automatic logic [32:0] read_word(
    input mux_state_t st,
    input logic [7:0] addr,
    input logic [NUM_GPIO-1:0] pins,
    input logic [2:0] straps,
    input logic link_need,
    input logic sda
  );
    logic [32:0] r;
    r = '0;
    unique case (addr)
      hotplug_mux_pkg::OFS_GPIO_CTRL_A: r[7:0] = st.ctrl_a;
      hotplug_mux_pkg::OFS_GPIO_CTRL_B: r[7:0] = st.ctrl_b;
      hotplug_mux_pkg::OFS_GPIO_CTRL_C: r[2:0] = st.ctrl_c;
      hotplug_mux_pkg::OFS_GPIO_DATA: r[NUM_GPIO-1:0] = pins;
      hotplug_mux_pkg::OFS_STRAP_STATUS:
      begin
        r[hotplug_mux_pkg::STAT_STRAP_LSB +: 3] = straps;
        r[hotplug_mux_pkg::STAT_PRESENCE_LSB +: 3] = st.presence;
        r[hotplug_mux_pkg::STAT_POWER_GOOD_LSB +: 3] = st.power_good;
      end
      hotplug_mux_pkg::OFS_CLOCK_REQ:
      begin
        r[hotplug_mux_pkg::CLKREQ_SW_BIT] = st.clkreq_sw;
        r[hotplug_mux_pkg::CLKREQ_LINK_BIT] = link_need;
      end
      hotplug_mux_pkg::OFS_EEPROM_WIRE:
      begin
        r[hotplug_mux_pkg::EE_SCL_BIT] = st.ee_scl;
        r[hotplug_mux_pkg::EE_SDA_LOW_BIT] = st.ee_sda_low;
        r[hotplug_mux_pkg::EE_SDA_IN_BIT] = sda;
      end
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    logic [32:0] rd;
    logic [31:0] wv;
    rd = '0;
    wv = '0;
    nxt_d = cur_q;

    // Bus answer
    rd = read_word(cur_q, paddr, gpio_read, strap_q, link_clock_needed,
                   eeprom_sda_in);
    nxt_d.bus_ready = access;
    nxt_d.bus_err = access & rd[32];
    nxt_d.bus_rdata = (access & ~pwrite) ? rd[31:0] : 32'h00000000;

    // Register writes land on the completing edge only
    if (wr_done)
    begin
      unique case (paddr)
        hotplug_mux_pkg::OFS_GPIO_CTRL_A:
        begin
          wv = merge_lanes({24'h000000, cur_q.ctrl_a}, pwdata, pstrb);
          nxt_d.ctrl_a = wv[7:0];
        end
        hotplug_mux_pkg::OFS_GPIO_CTRL_B:
        begin
          wv = merge_lanes({24'h000000, cur_q.ctrl_b}, pwdata, pstrb);
          nxt_d.ctrl_b = wv[7:0];
        end
        hotplug_mux_pkg::OFS_GPIO_CTRL_C:
        begin
          wv = merge_lanes({29'h00000000, cur_q.ctrl_c}, pwdata, pstrb);
          nxt_d.ctrl_c = wv[2:0];
        end
        hotplug_mux_pkg::OFS_GPIO_DATA:
        begin
          wv = merge_lanes({13'h0000, cur_q.gpio_data}, pwdata, pstrb);
          nxt_d.gpio_data = wv[NUM_GPIO-1:0];
        end
        hotplug_mux_pkg::OFS_CLOCK_REQ:
        begin
          if (pstrb[0])
          begin
            nxt_d.clkreq_sw = pwdata[hotplug_mux_pkg::CLKREQ_SW_BIT];
          end
        end
        hotplug_mux_pkg::OFS_EEPROM_WIRE:
        begin
          if (pstrb[0])
          begin
            nxt_d.ee_scl = pwdata[hotplug_mux_pkg::EE_SCL_BIT];
            nxt_d.ee_sda_low = pwdata[hotplug_mux_pkg::EE_SDA_LOW_BIT];
          end
        end
        default: nxt_d.ctrl_a = cur_q.ctrl_a;
      endcase
    end

    // Pin and slot outputs, registered so the pads never glitch
    nxt_d.pin_out = pin_out_d;
    nxt_d.pin_oe_n = pin_oe_n_d;
    nxt_d.presence = presence_d;
    nxt_d.power_good = power_good_d;

    nxt_d.clkreq_n = ~(cur_q.clkreq_sw | link_clock_needed);

    if (sys_reset)
    begin
      nxt_d.ctrl_a = hotplug_mux_pkg::RST_GPIO_CTRL_A;
      nxt_d.ctrl_b = hotplug_mux_pkg::RST_GPIO_CTRL_B;
      nxt_d.ctrl_c = hotplug_mux_pkg::RST_GPIO_CTRL_C;
      nxt_d.gpio_data = hotplug_mux_pkg::RST_GPIO_DATA;
      nxt_d.clkreq_sw = hotplug_mux_pkg::RST_CLKREQ_SW;
      nxt_d.ee_scl = hotplug_mux_pkg::RST_EE_SCL;
      nxt_d.ee_sda_low = hotplug_mux_pkg::RST_EE_SDA_LOW;
      nxt_d.bus_ready = 1'b0;
      nxt_d.bus_err = 1'b0;
      nxt_d.bus_rdata = 32'h00000000;
      nxt_d.pin_out = '0;
      nxt_d.pin_oe_n = '1;
      nxt_d.presence = 3'h0;
      nxt_d.power_good = 3'h0;
      nxt_d.clkreq_n = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge mclk)
  begin
    cur_q <= nxt_d;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign prdata = cur_q.bus_rdata;
  assign pready = cur_q.bus_ready;
  assign pslverr = cur_q.bus_err;
  assign gpio_out = cur_q.pin_out;
  assign gpio_oe_n = cur_q.pin_oe_n;
  assign slot_presence = cur_q.presence;
  assign slot_power_good = cur_q.power_good;
  assign upstream_clock_request_n = cur_q.clkreq_n;

  // clock out only, data open drain
  assign eeprom_scl = cur_q.ee_scl;
  assign eeprom_sda_out = 1'b0;
  assign eeprom_sda_oe_n = ~cur_q.ee_sda_low;

endmodule

`default_nettype wire

//--- verif/slot_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Board: pins, slots, EEPROM wire, clock
// ========================================
module slot_board_model
(
  input wire logic mclk,
  input wire logic [18:0] gpio_out,
  input wire logic [18:0] gpio_oe_n,
  input wire logic [18:0] ext_level,
  input wire logic eeprom_sda_out,
  input wire logic eeprom_sda_oe_n,
  input wire logic upstream_clock_request_n,
  output logic [18:0] gpio_in,
  output logic eeprom_sda_in,
  output logic ref_clock_on
);
  // Released pins show the board level, never the stale drive value
  assign gpio_in = (gpio_out & ~gpio_oe_n) | (ext_level & gpio_oe_n);
  assign eeprom_sda_in = eeprom_sda_oe_n ? 1'b1 : eeprom_sda_out;
  always_ff @(posedge mclk)
  begin
    ref_clock_on <= !upstream_clock_request_n;
  end
endmodule

`default_nettype wire

//--- verif/hotplug_strap_gpio_mux_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Port-level checks
// ========================================
module hotplug_strap_gpio_mux_assertions
#(
  parameter int unsigned NUM_GPIO = 19
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic fundamental_reset_n,
  input wire logic global_power_on_reset_n,
  input wire logic port1_hotplug_strap,
  input wire logic port2_hotplug_strap,
  input wire logic port3_hotplug_strap,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_GPIO-1:0] gpio_in,
  input wire logic [NUM_GPIO-1:0] gpio_out,
  input wire logic [NUM_GPIO-1:0] gpio_oe_n,
  input wire logic [2:0] slot_power_on,
  input wire logic [2:0] slot_presence,
  input wire logic [2:0] slot_power_good,
  input wire logic link_clock_needed,
  input wire logic upstream_clock_request_n,
  input wire logic eeprom_scl,
  input wire logic eeprom_sda_out,
  input wire logic eeprom_sda_oe_n
);
  logic rst, settled;
  logic [1:0] since_q;
  logic [2:0] cap_q, pres_in, gd_in, pw_oe, pw_out, sense_oe;

  // Slot pin groups, port 1 in bit 0
  assign rst = reset | !fundamental_reset_n | !global_power_on_reset_n;
  assign settled = !rst && (since_q == 2'h2);
  assign pres_in = {gpio_in[8], gpio_in[4], gpio_in[0]};
  assign gd_in = {gpio_in[10], gpio_in[6], gpio_in[2]};
  assign pw_oe = {gpio_oe_n[9], gpio_oe_n[5], gpio_oe_n[1]};
  assign pw_out = {gpio_out[9], gpio_out[5], gpio_out[1]};
  assign sense_oe = {gpio_oe_n[8], gpio_oe_n[4], gpio_oe_n[0]} &
                    {gpio_oe_n[10], gpio_oe_n[6], gpio_oe_n[2]};

  // Own strap copy; claims only count two edges after release
  always_ff @(posedge mclk)
  begin
    if (rst)
      since_q <= 2'h0;
    else if (since_q != 2'h2)
      since_q <= since_q + 2'h1;
    if (!rst && since_q == 2'h0)
      cap_q <= {port3_hotplug_strap, port2_hotplug_strap,
                port1_hotplug_strap};
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_RESET_IDLE: assert property (disable iff (reset)
    (!fundamental_reset_n || !global_power_on_reset_n) |=> (&gpio_oe_n)
    && slot_presence == 3'h0 && slot_power_good == 3'h0
    && upstream_clock_request_n && eeprom_scl && eeprom_sda_oe_n)
    else $error("outputs not idle under reset");
  AST_CLKREQ_LINK: assert property (
    link_clock_needed |=> !upstream_clock_request_n)
    else $error("clock request not low");
  AST_SDA_PULL_ONLY: assert property (eeprom_sda_out == 1'b0)
    else $error("sda driven high");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_POWER_ON_DRIVE: assert property (settled |->
    (pw_oe & cap_q) == 3'h0 &&
    (pw_out & cap_q) == ($past(slot_power_on) & cap_q))
    else $error("power-on pin not driven");
  AST_SENSE_RELEASED: assert property (
    settled |-> (sense_oe & cap_q) == cap_q)
    else $error("sense pin driven");
  AST_PRESENCE: assert property (
    settled |-> slot_presence == ($past(pres_in) & cap_q))
    else $error("slot presence wrong");
  AST_POWER_GOOD: assert property (
    settled |-> slot_power_good == ($past(gd_in) & cap_q))
    else $error("slot power good wrong");

  // Main scenarios reached
  cover property (settled && cap_q == 3'h7);
  cover property (pready && pslverr);
  cover property (!upstream_clock_request_n && !link_clock_needed);
endmodule

bind hotplug_strap_gpio_mux hotplug_strap_gpio_mux_assertions
  #(.NUM_GPIO(NUM_GPIO)) hotplug_strap_gpio_mux_assertions_inst (.*);

`default_nettype wire

//--- verif/tb_hotplug_strap_gpio_mux.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Stimulus, reference model and checks
// ========================================
module tb_hotplug_strap_gpio_mux;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic fundamental_reset_n = 1'b1;
  logic global_power_on_reset_n = 1'b1;
  logic [2:0] strap = 3'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] slot_power_on = 3'h0;
  logic link_clock_needed = 1'b0;
  logic [18:0] ext_level = 19'h0;
  logic [31:0] prdata;
  logic pready, pslverr, eeprom_scl, eeprom_sda_in, eeprom_sda_out;
  logic eeprom_sda_oe_n, upstream_clock_request_n, ref_clock_on;
  logic [18:0] gpio_in, gpio_out, gpio_oe_n;
  logic [2:0] slot_presence, slot_power_good;
  // Reference model state
  logic [2:0] cap;
  logic [18:0] dir, dat;
  logic [31:0] rd, v;
  logic err;
  int failures = 0;
  int checks = 0;

  hotplug_strap_gpio_mux hotplug_strap_gpio_mux_inst (
    .port1_hotplug_strap(strap[0]),
    .port2_hotplug_strap(strap[1]),
    .port3_hotplug_strap(strap[2]),
    .*
  );
  slot_board_model slot_board_model_inst (.*);

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", 0, n >= 20);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask

  // Model the pin map from the straps taken at release
  task automatic pins_chk();
    logic [18:0] oe, out, lvl, cm;
    logic [2:0] pr, gd;
    oe = ~dir;
    out = dat;
    cm = 19'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (cap[i])
      begin
        oe[4*i +: 3] = 3'b101;
        out[4*i+1] = slot_power_on[i];
        cm[4*i +: 3] = 3'b111;
      end
    end
    lvl = (out & ~oe) | (ext_level & oe);
    pr = {lvl[8], lvl[4], lvl[0]} & cap;
    gd = {lvl[10], lvl[6], lvl[2]} & cap;
    chk("gpio_oe_n", oe, gpio_oe_n);
    chk("gpio_out", out & ~oe, gpio_out);
    chk("slot_presence", pr, slot_presence);
    chk("slot_power_good", gd, slot_power_good);
    rdchk(hotplug_mux_pkg::OFS_STRAP_STATUS,
          {21'h0, gd, 1'b0, pr, 1'b0, cap});
    rdchk(hotplug_mux_pkg::OFS_GPIO_DATA, {13'h0, lvl & ~cm});
  endtask

  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog far beyond the expected run length
  initial
  begin
    #200000;
    failures++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h2b29));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    // Register reset values and an unmapped hole
    rdchk(hotplug_mux_pkg::OFS_GPIO_CTRL_A, 32'h0);
    rdchk(hotplug_mux_pkg::OFS_GPIO_CTRL_B, 32'h0);
    rdchk(hotplug_mux_pkg::OFS_GPIO_CTRL_C, 32'h0);
    rdchk(hotplug_mux_pkg::OFS_CLOCK_REQ, 32'h0);
    rdchk(hotplug_mux_pkg::OFS_EEPROM_WIRE, 32'h5);
    rdchk(8'h1c, 32'h0);
    chk("pslverr", 1, err);
    // Every strap pattern, the reset source rotating through the three
    for (int s = 0; s < 8; s++)
    begin
      strap <= s[2:0];
      reset <= (s % 3 == 0);
      fundamental_reset_n <= (s % 3 != 1);
      global_power_on_reset_n <= (s % 3 != 2);
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      fundamental_reset_n <= 1'b1;
      global_power_on_reset_n <= 1'b1;
      @(posedge mclk);
      // Straps flip after the capture edge and must be ignored
      strap <= ~s[2:0];
      cap = s[2:0];
      v = $urandom;
      ext_level <= v[18:0];
      slot_power_on <= v[21:19];
      v = $urandom;
      dir = v[18:0];
      apb(1'b1, hotplug_mux_pkg::OFS_GPIO_CTRL_A, {24'h0, dir[7:0]});
      apb(1'b1, hotplug_mux_pkg::OFS_GPIO_CTRL_B, {24'h0, dir[15:8]});
      apb(1'b1, hotplug_mux_pkg::OFS_GPIO_CTRL_C, {29'h0, dir[18:16]});
      v = $urandom;
      dat = v[18:0];
      apb(1'b1, hotplug_mux_pkg::OFS_GPIO_DATA, {13'h0, dat});
      repeat (2) @(posedge mclk);
      pins_chk();
    end
    // Clock request from the link, then from software
    link_clock_needed <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("clkreq_n", 0, upstream_clock_request_n);
    chk("ref_clock_on", 1, ref_clock_on);
    rdchk(hotplug_mux_pkg::OFS_CLOCK_REQ, 32'h2);
    link_clock_needed <= 1'b0;
    apb(1'b1, hotplug_mux_pkg::OFS_CLOCK_REQ, 32'h1);
    repeat (2) @(posedge mclk);
    chk("clkreq_n", 0, upstream_clock_request_n);
    apb(1'b1, hotplug_mux_pkg::OFS_CLOCK_REQ, 32'h0);
    repeat (2) @(posedge mclk);
    chk("clkreq_n", 1, upstream_clock_request_n);
    // EEPROM wires: clock low, data pulled low, then released
    apb(1'b1, hotplug_mux_pkg::OFS_EEPROM_WIRE, 32'h2);
    repeat (2) @(posedge mclk);
    chk("scl", 0, eeprom_scl);
    chk("sda_oe_n", 0, eeprom_sda_oe_n);
    rdchk(hotplug_mux_pkg::OFS_EEPROM_WIRE, 32'h2);
    apb(1'b1, hotplug_mux_pkg::OFS_EEPROM_WIRE, 32'h1);
    repeat (2) @(posedge mclk);
    chk("sda_oe_n", 1, eeprom_sda_oe_n);
    rdchk(hotplug_mux_pkg::OFS_EEPROM_WIRE, 32'h5);
    // Lanes switched off and unmapped writes must change nothing
    pstrb <= 4'h0;
    apb(1'b1, hotplug_mux_pkg::OFS_GPIO_CTRL_A, 32'hff);
    pstrb <= 4'hf;
    apb(1'b1, 8'h1c, 32'hff);
    chk("pslverr", 1, err);
    rdchk(hotplug_mux_pkg::OFS_GPIO_CTRL_A, {24'h0, dir[7:0]});
    conclude();
  end
endmodule

`default_nettype wire
